// ===== src/odt_pd_pkg.sv
// constants and types for the power-down termination mode tracker
package odt_pd_pkg;
   // clock period of the device clock, in picoseconds
   localparam int CLK_PERIOD_PS = 100000;
   // asynchronous turn-on and turn-off window, in picoseconds
   localparam int ASYNC_MIN_PS = 2000;
   localparam int ASYNC_MAX_PS = 8500;
   // least time rounds up and is never under one cycle
   localparam int ASYNC_DLY_RAW = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int ASYNC_DLY_CYC = (ASYNC_DLY_RAW < 1) ? 1 : ASYNC_DLY_RAW;
   // synchronous latency is write latency minus this amount
   localparam int SYNC_LAT_SUB = 2;
   // entry lead time is the latency plus this amount
   localparam int LEAD_ADD = 1;
   // latency field widths
   localparam int CWL_W = 4;
   localparam int AL_W = 4;
   // default widths and counts
   localparam int DEF_MAX_LAT = 30;
   localparam int DEF_RFC_CYC = 11;
   localparam int DEF_XPDLL_CYC = 10;
   localparam int CNT_W = 16;
   // reset values of the state outputs
   localparam logic RTT_RST = 1'b0;
   localparam logic ASYNC_RST = 1'b0;
   localparam logic TRANS_RST = 1'b0;
   // termination response mode
   typedef enum logic [1:0] {
      ST_SYNC,
      ST_ENTRY,
      ST_ASYNC,
      ST_EXIT
   } odt_mode_t;
   // synchronous turn-on and turn-off latency in cycles
   function automatic int sync_lat(input logic [CWL_W-1:0] cwl,
                                   input logic [AL_W-1:0] al);
      return int'(cwl) + int'(al) - SYNC_LAT_SUB;
   endfunction
   // lead time before the cke sample that opens a transition period
   function automatic int lead_time(input logic [CWL_W-1:0] cwl,
                                    input logic [AL_W-1:0] al);
      return sync_lat(cwl, al) + LEAD_ADD;
   endfunction
endpackage

// ===== src/odt_pd_transition.sv
// termination mode tracker around precharge power-down entry and exit
`timescale 1ns/10ps
`default_nettype none
module odt_pd_transition
   import odt_pd_pkg::*;
#(
   parameter int MAX_LAT = odt_pd_pkg::DEF_MAX_LAT,
   parameter int RFC_CYC = odt_pd_pkg::DEF_RFC_CYC,
   parameter int XPDLL_CYC = odt_pd_pkg::DEF_XPDLL_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_cke,
   input wire logic i_odt,
   input wire logic i_refresh,
   input wire logic i_dll_on_in_pd,
   input wire logic [odt_pd_pkg::CWL_W-1:0] i_cwl,
   input wire logic [odt_pd_pkg::AL_W-1:0] i_al,
   output logic o_rtt_on,
   output logic o_async_mode,
   output logic o_transition
);
   import odt_pd_pkg::*;

   // delay ranges in the checks below cannot reach past this many cycles
   localparam int CHK_SPAN = 1000;

   // refuse settings the history, counters or checks cannot hold
   if (MAX_LAT < 2 || RFC_CYC < 1 || XPDLL_CYC < 1 ||
       RFC_CYC >= (1 << CNT_W) || XPDLL_CYC >= (1 << CNT_W) ||
       RFC_CYC > CHK_SPAN || XPDLL_CYC > CHK_SPAN ||
       ASYNC_DLY_CYC > MAX_LAT) begin : g_bad_param
      $error("odt_pd_transition: unsupported parameter values");
   end

   localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(RFC_CYC);
   localparam logic [CNT_W-1:0] XPDLL_LOAD = CNT_W'(XPDLL_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   odt_mode_t mode_r;
   logic [MAX_LAT-1:0] odt_hist_r;
   logic [CNT_W-1:0] rfc_cnt_r;
   logic [CNT_W-1:0] xp_cnt_r;
   logic cke_r;
   logic rtt_nxt;
   logic async_nxt;
   logic trans_nxt;
   logic cke_fall;
   logic cke_rise;
   int lat;
   logic lat_ok;

   // latency from the programmed write latency fields
   assign lat = sync_lat(i_cwl, i_al);
   assign lat_ok = (lat >= 1) && (lat <= MAX_LAT);
   assign cke_fall = cke_r && !i_cke;
   assign cke_rise = !cke_r && i_cke;

   // history of registered odt; index n is n+1 edges old
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         odt_hist_r <= '0;
      end else begin
         odt_hist_r <= {odt_hist_r[MAX_LAT-2:0], i_odt};
      end
   end

   // last registered cke level, for edge detection
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cke_r <= 1'b1;
      end else begin
         cke_r <= i_cke;
      end
   end

   // cycles left of the refresh cycle time after each refresh command
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rfc_cnt_r <= CNT_ZERO;
      end else if (i_refresh) begin
         rfc_cnt_r <= RFC_LOAD;
      end else if (rfc_cnt_r != CNT_ZERO) begin
         rfc_cnt_r <= rfc_cnt_r - CNT_ONE;
      end
   end

   // exit period timer, loaded at the first cke high sample
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         xp_cnt_r <= CNT_ZERO;
      end else if (mode_r == ST_ASYNC && i_cke) begin
         xp_cnt_r <= XPDLL_LOAD;
      end else if (xp_cnt_r != CNT_ZERO) begin
         xp_cnt_r <= xp_cnt_r - CNT_ONE;
      end
   end

   // mode sequencing; the lead part of each period runs in the mode before it,
   // where an odt change already lands no later than the lead time
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_r <= ST_SYNC;
      end else if (i_dll_on_in_pd) begin
         mode_r <= ST_SYNC; // dll kept running: always latency based
      end else begin
         unique case (mode_r)
            ST_SYNC: begin
               if (cke_fall && rfc_cnt_r > CNT_ONE) begin
                  mode_r <= ST_ENTRY; // refresh still running
               end else if (cke_fall) begin
                  mode_r <= ST_ASYNC; // entry ends at cke low
               end
            end
            ST_ENTRY: begin
               if (rfc_cnt_r <= CNT_ONE) begin
                  mode_r <= ST_ASYNC;
               end
            end
            ST_ASYNC: begin
               if (i_cke) begin
                  mode_r <= ST_EXIT;
               end
            end
            ST_EXIT: begin
               if (!i_cke) begin
                  mode_r <= ST_ASYNC; // short high pulse
               end else if (xp_cnt_r == CNT_ONE) begin
                  mode_r <= ST_SYNC;
               end
            end
         endcase
      end
   end

   // termination response: sync taps the latency, others use the fixed
   // async delay; inside a period the async figure is the earlier bound
   // and lies inside the widened window either way
   always_comb begin
      rtt_nxt = o_rtt_on;
      async_nxt = (mode_r != ST_SYNC);
      trans_nxt = (mode_r == ST_ENTRY) || (mode_r == ST_EXIT);
      if (mode_r == ST_SYNC) begin
         if (lat_ok) begin
            rtt_nxt = odt_hist_r[lat-1];
         end
      end else begin
         // no additive latency on this path
         rtt_nxt = odt_hist_r[ASYNC_DLY_CYC-1];
      end
   end

   // registered outputs
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rtt_on <= RTT_RST;
         o_async_mode <= ASYNC_RST;
         o_transition <= TRANS_RST;
      end else begin
         o_rtt_on <= rtt_nxt;
         o_async_mode <= async_nxt;
         o_transition <= trans_nxt;
      end
   end

   // checks, one clock domain
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   localparam int XP_CHK = XPDLL_CYC;
   localparam int RFC_CHK = RFC_CYC;

   sequence s_enter_low;
      mode_r == ST_SYNC && !i_dll_on_in_pd && cke_fall;
   endsequence

   sequence s_wake;
      mode_r == ST_ASYNC && !i_dll_on_in_pd && i_cke;
   endsequence

   property p_dll_on_sync;
      i_dll_on_in_pd |=> mode_r == ST_SYNC ##1 !o_async_mode;
   endproperty
   a_dll_on_sync: assert property (p_dll_on_sync)
      else $error("mode left sync with dll kept on");

   property p_entry_ends;
      s_enter_low ##0 (rfc_cnt_r <= CNT_ONE) |=> mode_r == ST_ASYNC;
   endproperty
   a_entry_ends: assert property (p_entry_ends)
      else $error("entry did not end at cke low");

   property p_refresh_hold;
      s_enter_low ##0 (rfc_cnt_r > CNT_ONE) |=> mode_r == ST_ENTRY;
   endproperty
   a_refresh_hold: assert property (p_refresh_hold)
      else $error("entry left before refresh done");

   property p_entry_stays;
      mode_r == ST_ENTRY && !i_dll_on_in_pd && rfc_cnt_r > CNT_ONE
         |=> mode_r == ST_ENTRY;
   endproperty
   a_entry_stays: assert property (p_entry_stays)
      else $error("entry left while refresh still running");

   property p_refresh_bound;
      mode_r == ST_ENTRY && !i_dll_on_in_pd |-> ##[1:RFC_CHK]
         mode_r == ST_ASYNC;
   endproperty
   a_refresh_bound: assert property (p_refresh_bound)
      else $error("entry period outlasted refresh time");

   property p_exit_len;
      s_wake ##1 (i_cke && !i_dll_on_in_pd) [*2] |->
         ##[0:XP_CHK] mode_r == ST_SYNC;
   endproperty
   a_exit_len: assert property (p_exit_len)
      else $error("exit period too long");

   property p_async_resp;
      mode_r != ST_SYNC && $changed(i_odt) |->
         ##(ASYNC_DLY_CYC + 1) (o_rtt_on == $past(i_odt, ASYNC_DLY_CYC + 1)
         || mode_r == ST_SYNC);
   endproperty
   a_async_resp: assert property (p_async_resp)
      else $error("async response not at fixed delay");

   property p_sync_resp;
      mode_r == ST_SYNC && !$past(mode_r != ST_SYNC) && lat_ok && lat == 3
         |=> o_rtt_on == $past(i_odt, 4);
   endproperty
   a_sync_resp: assert property (p_sync_resp)
      else $error("sync response not at latency");

   property p_short_high;
      mode_r == ST_EXIT && !i_cke && !i_dll_on_in_pd |=>
         mode_r == ST_ASYNC ##1 o_async_mode;
   endproperty
   a_short_high: assert property (p_short_high)
      else $error("short high pulse lost async response");

   property p_flags;
      ##1 o_transition |-> o_async_mode;
   endproperty
   a_flags: assert property (p_flags)
      else $error("transition flag without async mode");

   // odt moved inside an exit period answers at the fixed async delay
   sequence s_exit_odt;
      mode_r == ST_EXIT && !i_dll_on_in_pd && $changed(i_odt)
         ##1 mode_r == ST_EXIT;
   endsequence

   property p_exit_resp;
      s_exit_odt |=> o_rtt_on == $past(i_odt, 2);
   endproperty
   a_exit_resp: assert property (p_exit_resp)
      else $error("exit period response outside bounds");
endmodule // odt_pd_transition
`default_nettype wire

// ===== verif/ddr_ctrl_model.sv
// behavioural memory controller driving clock enable, termination, refresh
`timescale 1ns/10ps
`default_nettype none
module ddr_ctrl_model #(
   parameter int LEAD = 4
) (
   input wire logic i_ref_clk,
   output var logic o_cke,
   output var logic o_odt,
   output var logic o_refresh
);
   // awake, unterminated and idle from time zero
   initial begin
      o_cke = 1'b1;
      o_odt = 1'b0;
      o_refresh = 1'b0;
   end
   // termination request changes only just after an edge
   task automatic set_odt(input logic v);
      @(posedge i_ref_clk);
      o_odt <= v;
   endtask
   // odt held still for the lead time, so no change lands in the window
   task automatic set_cke(input logic v);
      repeat (LEAD) @(posedge i_ref_clk);
      o_cke <= v;
   endtask
   // cke to v for len edges, then back; the periods overlap
   task automatic pulse_cke(input logic v, input int len);
      repeat (LEAD) @(posedge i_ref_clk);
      o_cke <= v;
      repeat (len) @(posedge i_ref_clk);
      o_cke <= ~v;
   endtask
   // single-cycle refresh strobe, cke still high when issued
   task automatic refresh_pulse;
      @(posedge i_ref_clk);
      o_refresh <= 1'b1;
      @(posedge i_ref_clk);
      o_refresh <= 1'b0;
   endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the power-down termination mode tracker
`timescale 1ns/10ps
`default_nettype none
module tb;
   import odt_pd_pkg::*;
   localparam int RFC_P = 12;
   localparam int XPDLL_P = 4;
   localparam int LAT_S = 3; // cwl 3 plus al 2 less two
   localparam int LEAD_P = LAT_S + 1;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic dll_on = 1'b0;
   logic [CWL_W-1:0] cwl = 4'h3;
   logic [AL_W-1:0] al = 4'h2;
   logic cke, odt, refresh, rtt_on, async_mode, transition;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   // free-running device clock, 100 ns period
   always #50 clk = ~clk;
   ddr_ctrl_model #(.LEAD(LEAD_P)) u_ctrl (.i_ref_clk(clk), .o_cke(cke),
      .o_odt(odt), .o_refresh(refresh));
   odt_pd_transition #(.RFC_CYC(RFC_P), .XPDLL_CYC(XPDLL_P)) DUT (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_cke(cke), .i_odt(odt),
      .i_refresh(refresh), .i_dll_on_in_pd(dll_on), .i_cwl(cwl),
      .i_al(al), .o_rtt_on(rtt_on), .o_async_mode(async_mode),
      .o_transition(transition));
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // guard against a hang: the tests need under two hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         $display("[FAIL] timeout expected done seen hung");
         give_verdict();
      end
   end
   task automatic check(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
         n_fail++;
      end
   endtask
   // change odt, then the response must land at edge lat+1 after the change, not before
   task automatic resp(input int lat, input logic v);
      u_ctrl.set_odt(v);
      repeat (lat) @(posedge clk);
      #1;
      check("rtt before latency", ~v, rtt_on);
      @(posedge clk);
      #1;
      check("rtt at latency", v, rtt_on);
   endtask
   task automatic t_sync;
      resp(LAT_S, 1'b1);
      resp(LAT_S, 1'b0);
      $display("test sync latency done");
   endtask
   task automatic t_entry;
      u_ctrl.set_cke(1'b0);
      repeat (3) @(posedge clk);
      #1;
      check("async after entry", 1'b1, async_mode);
      check("no stretch", 1'b0, transition);
      resp(1, 1'b1);
      resp(1, 1'b0);
      $display("test entry done");
   endtask
   // exit period must last about the exit time, then sync returns
   task automatic t_exit;
      int cnt;
      cnt = 0;
      u_ctrl.set_cke(1'b1);
      for (int i = 0; i < XPDLL_P + 6; i++) begin
         // odt pulse inside the exit period, answered at async delay
         if (i == 1 || i == 3) begin
            u_ctrl.set_odt(i == 1);
         end else begin
            @(posedge clk);
         end
         #1;
         if (i == 3) check("rtt in exit", 1'b1, rtt_on);
         if (transition === 1'b1) cnt++;
      end
      check("exit length", 1'b1,
         (cnt >= XPDLL_P - 2) && (cnt <= XPDLL_P + 1));
      check("sync after exit", 1'b0, async_mode);
      resp(LAT_S, 1'b1);
      resp(LAT_S, 1'b0);
      $display("test exit done");
   endtask
   // refresh still running at cke low stretches the entry period
   task automatic t_refresh;
      int cnt;
      cnt = 0;
      u_ctrl.refresh_pulse();
      u_ctrl.set_cke(1'b0);
      repeat (20) begin
         @(posedge clk);
         #1;
         if (transition === 1'b1) cnt++;
      end
      check("stretch length", 1'b1,
         (cnt >= 1) && (cnt <= RFC_P - LEAD_P + 1));
      check("async after stretch", 1'b1, async_mode);
      check("stretch over", 1'b0, transition);
      $display("test refresh entry done");
   endtask
   // short cke pulses: overlapping periods chain through exit and async
   task automatic t_short;
      u_ctrl.set_cke(1'b0);
      u_ctrl.pulse_cke(1'b1, 2);
      repeat (3) @(posedge clk);
      #1;
      check("async after short high", 1'b1, async_mode);
      check("short high period over", 1'b0, transition);
      u_ctrl.set_cke(1'b1);
      repeat (XPDLL_P + 2) @(posedge clk);
      u_ctrl.pulse_cke(1'b0, 2);
      repeat (2) @(posedge clk);
      #1;
      check("period in short low", 1'b1, transition);
      check("async in short low", 1'b1, async_mode);
      repeat (XPDLL_P + 1) @(posedge clk);
      #1;
      check("sync after short low", 1'b0, async_mode);
      check("short low period over", 1'b0, transition);
      $display("test short cke pulses done");
   endtask
   // dll kept on: power-down leaves the response synchronous
   task automatic t_dll_on;
      @(posedge clk);
      dll_on <= 1'b1;
      u_ctrl.set_cke(1'b0);
      repeat (4) @(posedge clk);
      #1;
      check("no async with dll on", 1'b0, async_mode);
      resp(LAT_S, 1'b1);
      resp(LAT_S, 1'b0);
      u_ctrl.set_cke(1'b1);
      $display("test dll kept on done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_sync();
      t_entry();
      t_exit();
      t_refresh();
      t_exit();
      t_short();
      t_dll_on();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
